// >>> rtl/sre_consts.svh
// Constants of the two-wire serial EEPROM read engine
`ifndef SRE_CONSTS_SVH
`define SRE_CONSTS_SVH
`define SRE_CLK_PERIOD_NS 4
`define SRE_SCL_HALF_NS 500
// Least half period of the bus clock, rounded up to whole core cycles
`define SRE_SCL_HALF_CYC ((`SRE_SCL_HALF_NS + `SRE_CLK_PERIOD_NS - 1) / `SRE_CLK_PERIOD_NS)
`define SRE_DEV_MAIN 4'ha
`define SRE_DEV_SPEC 4'hb
`define SRE_SEL_SECTOR 2'b00
`define SRE_SEL_LOCK 2'b01
`define SRE_SEL_UID 2'b10
`define SRE_LOCK_BIT 1
`define SRE_PAGE_MASK 8'h0f
`define SRE_MAIN_WORDS 256
`define SRE_SPEC_WORDS 16
`define SRE_FIFO_DEPTH 16
`define SRE_FIFO_WIDTH 8
`define SRE_LAST_BIT 4'h7
`define SRE_ACK_BIT 4'h8
`endif

// >>> rtl/sre_ctrl.sv
// Bus controller end: issues read, probe and status sequences
`include "sre_consts.svh"
module sre_ctrl #(
   parameter int SCL_HALF = `SRE_SCL_HALF_CYC,
   parameter int FIFO_DEPTH = `SRE_FIFO_DEPTH
) (
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   input wire logic i_cmd_valid,
   output logic o_cmd_ready,
   input wire sre_pkg::sre_cmd_t i_cmd_kind,
   input wire logic [7:0] i_cmd_word,
   input wire logic [7:0] i_cmd_count,
   input wire logic [2:0] i_cmd_cs,
   output logic [7:0] o_rd_data,
   output logic o_rd_valid,
   input wire logic i_rd_ready,
   output logic o_done,
   output logic o_addr_nack,
   output logic o_sector_locked,
   sre_if.host bus
);
   import sre_pkg::*;

   sre_host_t q;
   sre_host_t d;
   logic tick;
   logic stall;
   logic push;
   logic fifo_ready;
   logic ackn;

   function automatic logic [7:0] word_for(input sre_cmd_t k, input logic [7:0] w);
      unique case (k)
         C_UID: word_for = {`SRE_SEL_UID, 2'b00, w[3:0]};
         C_SECTOR, C_PROBE: word_for = {`SRE_SEL_SECTOR, 2'b00, w[3:0]};
         C_LOCK: word_for = {`SRE_SEL_LOCK, 6'h00};
         default: word_for = w;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Bus clock is stretched low before a byte the FIFO cannot take
   assign stall = (q.st == H_RX) && q.sub == 2'd0 && q.bitn == 4'h0 && !fifo_ready;
   assign tick = (q.tmr == 16'(SCL_HALF - 1)) && !stall;
   assign ackn = q.sda_s;
   assign push = (q.st == H_RX) && tick && q.sub == 2'd1 && q.bitn == `SRE_ACK_BIT;

   always_comb begin
      d = q;
      d.sda_m = bus.sda_line;
      d.sda_s = q.sda_m;
      d.done = 1'b0;
      d.tmr = (tick || stall) ? 16'h0 : q.tmr + 16'h1;
      unique case (q.st)
         H_IDLE: begin
            d.tmr = 16'h0;
            d.scl_oe = 1'b0;
            d.sda_oe = 1'b0;
            if (i_cmd_valid) begin
               d.kind = i_cmd_kind;
               d.cs = i_cmd_cs;
               d.word = word_for(i_cmd_kind, i_cmd_word);
               d.left = (i_cmd_count == 8'h00) ? 8'h01 : i_cmd_count;
               d.nack = 1'b0;
               d.stg = (i_cmd_kind == C_CURRENT) ? G_DEVR : G_DEVW;
               d.st = H_START;
               d.sub = 2'd0;
            end
         end
         H_START: begin
            d.scl_oe = (q.sub == 2'd0 || q.sub == 2'd3);
            d.sda_oe = (q.sub >= 2'd2);
            if (tick) begin
               d.sub = q.sub + 2'd1;
               if (q.sub == 2'd3) begin
                  d.sub = 2'd0;
                  d.bitn = 4'h0;
                  if (q.stg == G_PSTART) begin
                     d.st = H_STOP;
                  end else begin
                     d.st = H_TX;
                     d.sh = {(q.kind == C_CURRENT || q.kind == C_RANDOM) ? `SRE_DEV_MAIN
                             : `SRE_DEV_SPEC, q.cs, q.stg == G_DEVR};
                  end
               end
            end
         end
         H_TX: begin
            d.scl_oe = (q.sub == 2'd0);
            d.sda_oe = (q.bitn != `SRE_ACK_BIT) && !q.sh[7];
            if (tick) begin
               d.sub = q.sub + 2'd1;
               if (q.sub == 2'd1) begin
                  d.sub = 2'd0;
                  d.bitn = q.bitn + 4'h1;
                  d.sh = {q.sh[6:0], 1'b0};
                  if (q.bitn == `SRE_ACK_BIT) begin
                     d.bitn = 4'h0;
                     d.st = H_STOP;
                     unique case (q.stg)
                        G_DEVW: begin
                           d.nack = ackn;
                           if (!ackn) begin
                              d.st = H_TX;
                              d.stg = G_WORD;
                              d.sh = q.word;
                           end
                        end
                        G_WORD: begin
                           d.nack = ackn;
                           if (!ackn && q.kind == C_PROBE) begin
                              d.st = H_TX;
                              d.stg = G_PROBE;
                              d.sh = 8'h00;
                           end else if (!ackn) begin
                              d.st = H_START;
                              d.stg = G_DEVR;
                           end
                        end
                        G_PROBE: begin
                           d.locked = ackn;
                           d.st = H_START;
                           d.stg = G_PSTART;
                        end
                        G_DEVR: begin
                           d.nack = ackn;
                           if (!ackn) begin
                              d.st = H_RX;
                              d.stg = G_DATA;
                           end
                        end
                        default: begin
                           d.st = H_STOP;
                        end
                     endcase
                  end
               end
            end
         end
         H_RX: begin
            d.scl_oe = (q.sub == 2'd0);
            d.sda_oe = (q.bitn == `SRE_ACK_BIT) && q.left != 8'h01;
            if (tick) begin
               d.sub = q.sub + 2'd1;
               if (q.sub == 2'd1) begin
                  d.sub = 2'd0;
                  d.bitn = q.bitn + 4'h1;
                  if (q.bitn != `SRE_ACK_BIT) begin
                     d.sh = {q.sh[6:0], q.sda_s};
                  end else begin
                     d.bitn = 4'h0;
                     d.left = q.left - 8'h01;
                     if (q.left == 8'h01) begin
                        d.st = H_STOP;
                     end
                  end
               end
            end
         end
         H_STOP: begin
            d.scl_oe = (q.sub == 2'd0);
            d.sda_oe = (q.sub <= 2'd1);
            if (tick) begin
               d.sub = q.sub + 2'd1;
               if (q.sub == 2'd2) begin
                  d.sub = 2'd0;
                  d.st = H_IDLE;
                  d.done = 1'b1;
               end
            end
         end
         default: begin
            d.st = H_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   sre_fifo #(
      .WIDTH(`SRE_FIFO_WIDTH),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .i_core_clk(i_core_clk),
      .i_sys_rst(i_sys_rst),
      .i_in_valid(push),
      .o_in_ready(fifo_ready),
      .i_in_data(q.sh),
      .o_out_valid(o_rd_valid),
      .i_out_ready(i_rd_ready),
      .o_out_data(o_rd_data)
   );

   assign o_cmd_ready = (q.st == H_IDLE);
   assign o_done = q.done;
   assign o_addr_nack = q.nack;
   assign o_sector_locked = q.locked;
   assign bus.host_scl_o = 1'b0;
   assign bus.host_scl_oe = q.scl_oe;
   assign bus.host_sda_o = 1'b0;
   assign bus.host_sda_oe = q.sda_oe;
endmodule

// >>> rtl/sre_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`include "sre_consts.svh"
module sre_fifo #(
   parameter int WIDTH = `SRE_FIFO_WIDTH,
   parameter int DEPTH = `SRE_FIFO_DEPTH
) (
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [WIDTH-1:0] o_out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [0:DEPTH-1];
   logic [AW:0] wr_r;
   logic [AW:0] rd_r;
   logic full;
   logic empty;

   assign empty = (wr_r == rd_r);
   assign full = (wr_r[AW-1:0] == rd_r[AW-1:0]) && (wr_r[AW] != rd_r[AW]);
   assign o_in_ready = !full;
   assign o_out_valid = !empty;
   assign o_out_data = mem[rd_r[AW-1:0]];

   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         wr_r <= '0;
         rd_r <= '0;
      end else begin
         if (i_in_valid && !full) begin
            mem[wr_r[AW-1:0]] <= i_in_data;
            wr_r <= wr_r + 1'b1;
         end
         if (i_out_ready && !empty) begin
            rd_r <= rd_r + 1'b1;
         end
      end
   end
endmodule

// >>> rtl/sre_if.sv
// Two-wire bus between controller and EEPROM target, open-drain resolved
interface sre_if;
   logic host_scl_o;
   logic host_scl_oe;
   logic host_sda_o;
   logic host_sda_oe;
   logic dev_sda_o;
   logic dev_sda_oe;
   logic scl_line;
   logic sda_line;

   // Pull-ups: a line is low only while some party drives it low
   assign scl_line = !(host_scl_oe && !host_scl_o);
   assign sda_line = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));

   modport dev (input scl_line, input sda_line, output dev_sda_o, output dev_sda_oe);
   modport host (input scl_line, input sda_line, output host_scl_o, output host_scl_oe,
                 output host_sda_o, output host_sda_oe);
endinterface

// >>> rtl/sre_pkg.sv
// Types shared by both ends of the read engine
package sre_pkg;
   typedef enum logic [2:0] {D_IDLE, D_RX, D_ACK, D_TX, D_TXACK} sre_dst_t;
   typedef enum logic [1:0] {K_DEV, K_WORD, K_DATA} sre_rxk_t;
   typedef enum logic [1:0] {M_SECTOR, M_LOCK, M_UID} sre_spec_t;
   typedef enum logic [2:0] {H_IDLE, H_START, H_TX, H_RX, H_STOP} sre_hst_t;
   typedef enum logic [2:0] {G_DEVW, G_WORD, G_PROBE, G_DEVR, G_DATA, G_PSTART} sre_stg_t;
   typedef enum logic [2:0] {C_CURRENT, C_RANDOM, C_UID, C_SECTOR, C_LOCK, C_PROBE} sre_cmd_t;

   typedef struct packed {
      sre_dst_t st;
      sre_rxk_t rxk;
      sre_spec_t spec;
      logic [2:0] cs_m;
      logic [2:0] cs_s;
      logic scl_m;
      logic scl_s;
      logic scl_p;
      logic sda_m;
      logic sda_s;
      logic sda_p;
      logic [3:0] bitn;
      logic [7:0] sh;
      logic special;
      logic rd;
      logic ack_in;
      logic acking;
      logic locked;
      logic sda_oe;
      logic [7:0] addr;
      logic [3:0] sptr;
      logic [3:0] uptr;
   } sre_dev_t;

   typedef struct packed {
      sre_hst_t st;
      sre_stg_t stg;
      sre_cmd_t kind;
      logic [1:0] sub;
      logic [15:0] tmr;
      logic [3:0] bitn;
      logic [7:0] sh;
      logic [7:0] word;
      logic [2:0] cs;
      logic [7:0] left;
      logic sda_m;
      logic sda_s;
      logic scl_oe;
      logic sda_oe;
      logic nack;
      logic locked;
      logic done;
   } sre_host_t;
endpackage

// >>> rtl/sre_target.sv
// EEPROM target end of the two-wire read engine
// Notes on behaviour
// - Read frames start like writes, direction bit high
// - Address counter holds last access plus one
// - Read counter wraps last byte to first
// - Write counter wraps within the current page
// - After read address ack, send counter byte
// - Controller ends current read with nack, stop
// - Random read: dummy write, repeated start, read
// - Ack second address byte, send loaded byte
// - Acked bytes advance address and keep sending
// - Controller ends sequential read with nack, stop
// - Word address 10b selects identifier, low nibble
// - Identifier pointer wraps after sixteenth byte
// - Word address 00b selects sector, low nibble
// - Sector pointer advances, wraps 0Fh to 00h
// - Sector write acked only when unlocked
// - Controller abandons lock probe with start, stop
// - Start resets command logic, stop means standby
// - Word address 01b selects lock status
// - Lock status bit 1 shows lock active
// - Lock status byte repeats while acknowledged
// - Device code 1010 selects main array
// - Device code 1011 selects special areas
// - Select bits must match the select pins
// - Mismatch gives no ack, returns to standby
`include "sre_consts.svh"
module sre_target #(
   // Arbitrary identifier contents, byte 0 in the top bits
   parameter logic [127:0] UID_VALUE = 128'h5a5a_0001_0203_0405_0607_0809_0a0b_0c0d
) (
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   input wire logic i_chip_select_pin_high,
   input wire logic i_chip_select_pin_mid,
   input wire logic i_chip_select_pin_low,
   output logic o_sector_locked,
   output logic o_busy,
   sre_if.dev bus
);
   import sre_pkg::*;

   logic [7:0] mem [0:`SRE_MAIN_WORDS-1];
   logic [7:0] sect [0:`SRE_SPEC_WORDS-1];
   sre_dev_t q;
   sre_dev_t d;
   logic start;
   logic stop;
   logic rise;
   logic fall;
   logic match;
   logic mem_we;
   logic sect_we;
   logic [7:0] tx_byte;

   function automatic logic [7:0] page_inc(input logic [7:0] a);
      page_inc = (a & ~`SRE_PAGE_MASK) | ((a + 8'h01) & `SRE_PAGE_MASK);
   endfunction

   // Byte presented to the controller for the current area and pointers
   function automatic logic [7:0] fetch(input sre_dev_t s);
      if (!s.special) begin
         fetch = mem[s.addr];
      end else begin
         unique case (s.spec)
            M_SECTOR: fetch = sect[s.sptr];
            M_UID: fetch = UID_VALUE[{~s.uptr, 3'b111} -: 8];
            M_LOCK: fetch = 8'(s.locked) << `SRE_LOCK_BIT;
            default: fetch = 8'h00;
         endcase
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Bus conditions seen through the synchronisers
   assign start = q.scl_s && q.scl_p && q.sda_p && !q.sda_s;
   assign stop = q.scl_s && q.scl_p && !q.sda_p && q.sda_s;
   assign rise = q.scl_s && !q.scl_p;
   assign fall = !q.scl_s && q.scl_p;
   assign match = (q.sh[7:4] == `SRE_DEV_MAIN || q.sh[7:4] == `SRE_DEV_SPEC)
                  && (q.sh[3:1] == q.cs_s);
   assign tx_byte = fetch(q);

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      d = q;
      mem_we = 1'b0;
      sect_we = 1'b0;
      d.scl_m = bus.scl_line;
      d.scl_s = q.scl_m;
      d.scl_p = q.scl_s;
      d.sda_m = bus.sda_line;
      d.sda_s = q.sda_m;
      d.sda_p = q.sda_s;
      d.cs_m = {i_chip_select_pin_high, i_chip_select_pin_mid, i_chip_select_pin_low};
      d.cs_s = q.cs_m;
      if (start) begin
         // Any start abandons a half-received command; pointers and data bytes already acked keep their effect
         d.st = D_RX;
         d.rxk = K_DEV;
         d.bitn = 4'h0;
         d.sda_oe = 1'b0;
      end else if (stop) begin
         d.st = D_IDLE;
         d.sda_oe = 1'b0;
      end else begin
         unique case (q.st)
            D_IDLE: begin
               d.sda_oe = 1'b0;
            end
            D_RX: begin
               if (rise && q.bitn != `SRE_ACK_BIT) begin
                  d.sh = {q.sh[6:0], q.sda_s};
                  d.bitn = q.bitn + 4'h1;
               end else if (fall && q.bitn == `SRE_ACK_BIT) begin
                  d.st = D_ACK;
                  d.acking = 1'b0;
                  unique case (q.rxk)
                     K_DEV: begin
                        if (match) begin
                           d.special = (q.sh[7:4] == `SRE_DEV_SPEC);
                           d.rd = q.sh[0];
                           d.acking = 1'b1;
                        end else begin
                           d.st = D_IDLE;
                        end
                     end
                     K_WORD: begin
                        d.acking = 1'b1;
                        if (!q.special) begin
                           d.addr = q.sh;
                        end else if (q.sh[7:6] == `SRE_SEL_SECTOR) begin
                           d.spec = M_SECTOR;
                           d.sptr = q.sh[3:0];
                        end else if (q.sh[7:6] == `SRE_SEL_UID) begin
                           d.spec = M_UID;
                           d.uptr = q.sh[3:0];
                        end else begin
                           d.spec = M_LOCK;
                        end
                     end
                     K_DATA: begin
                        if (!q.special) begin
                           mem_we = 1'b1;
                           d.acking = 1'b1;
                           d.addr = page_inc(q.addr);
                        end else if (q.spec == M_SECTOR && !q.locked) begin
                           sect_we = 1'b1;
                           d.acking = 1'b1;
                           d.sptr = q.sptr + 4'h1;
                        end else if (q.spec == M_LOCK && !q.locked) begin
                           d.acking = 1'b1;
                           d.locked = q.sh[`SRE_LOCK_BIT];
                        end
                     end
                     default: begin
                        d.st = D_IDLE;
                     end
                  endcase
                  d.sda_oe = d.acking && d.st == D_ACK;
               end
            end
            D_ACK: begin
               if (fall) begin
                  d.sda_oe = 1'b0;
                  d.bitn = 4'h0;
                  if (!q.acking) begin
                     d.st = D_IDLE;
                  end else if (q.rxk == K_DEV && q.rd) begin
                     d.st = D_TX;
                     d.sh = tx_byte;
                     d.sda_oe = !tx_byte[7];
                  end else begin
                     d.st = D_RX;
                     d.rxk = (q.rxk == K_DEV) ? K_WORD : K_DATA;
                  end
               end
            end
            D_TX: begin
               if (fall) begin
                  if (q.bitn == `SRE_LAST_BIT) begin
                     d.st = D_TXACK;
                     d.sda_oe = 1'b0;
                     if (!q.special) begin
                        d.addr = q.addr + 8'h01;
                     end else if (q.spec == M_SECTOR) begin
                        d.sptr = q.sptr + 4'h1;
                     end else if (q.spec == M_UID) begin
                        d.uptr = q.uptr + 4'h1;
                     end
                  end else begin
                     d.sh = {q.sh[6:0], 1'b0};
                     d.bitn = q.bitn + 4'h1;
                     d.sda_oe = !q.sh[6];
                  end
               end
            end
            D_TXACK: begin
               if (rise) begin
                  d.ack_in = !q.sda_s;
               end else if (fall) begin
                  if (q.ack_in) begin
                     d.st = D_TX;
                     d.sh = tx_byte;
                     d.bitn = 4'h0;
                     d.sda_oe = !tx_byte[7];
                  end else begin
                     d.st = D_IDLE;
                  end
               end
            end
            default: begin
               d.st = D_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Cleared on reset as erased cells, so no unknown ever reaches the data line
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         for (int i = 0; i < `SRE_MAIN_WORDS; i++) begin
            mem[i] <= 8'h00;
         end
         for (int j = 0; j < `SRE_SPEC_WORDS; j++) begin
            sect[j] <= 8'h00;
         end
      end else begin
         if (mem_we) begin
            mem[q.addr] <= q.sh;
         end
         if (sect_we) begin
            sect[q.sptr] <= q.sh;
         end
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign o_sector_locked = q.locked;
   assign o_busy = (q.st != D_IDLE);
   assign bus.dev_sda_o = 1'b0;
   assign bus.dev_sda_oe = q.sda_oe;
endmodule

// >>> verif/sre_checker.sv
// Assertions on the two-wire lines between controller and target
module sre_checker (
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   input wire logic host_scl_o,
   input wire logic host_scl_oe,
   input wire logic host_sda_o,
   input wire logic host_sda_oe,
   input wire logic dev_sda_o,
   input wire logic dev_sda_oe,
   input wire logic scl_line,
   input wire logic sda_line
);
   logic scl_q, sda_q, rd_frame, first_byte, start_c, stop_c, rise_c;
   logic [3:0] bit_cnt;
   assign start_c = scl_q && scl_line && sda_q && !sda_line;
   assign stop_c = scl_q && scl_line && !sda_q && sda_line;
   assign rise_c = !scl_q && scl_line;
   ////////////////////////////////////////////////////////////////////////////////
   // Clock count since start; 8 marks the acknowledge slot
   always_ff @(posedge i_core_clk) begin
      scl_q <= i_sys_rst | scl_line;
      sda_q <= i_sys_rst | sda_line;
      if (i_sys_rst || start_c) begin
         bit_cnt <= 4'h0;
         first_byte <= 1'b1;
         rd_frame <= 1'b0;
      end else if (rise_c) begin
         bit_cnt <= (bit_cnt == 4'h8) ? 4'h0 : bit_cnt + 4'h1;
         if (bit_cnt == 4'h8) begin
            first_byte <= 1'b0;
         end
         if (first_byte && bit_cnt == 4'h7) begin
            rd_frame <= sda_line;
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_sys_rst);
   chk_od_values: assert property (!host_scl_o && !host_sda_o && !dev_sda_o)
      else $error("open drain value high");
   chk_dev_scl_low: assert property ($changed(dev_sda_oe) |-> !scl_line)
      else $error("target data moved with clock high");
   chk_ack_hold: assert property ($rose(scl_line) && dev_sda_oe |=> dev_sda_oe [*4])
      else $error("target data dropped with clock high");
   chk_stop_idle: assert property (stop_c |=> !dev_sda_oe [*8])
      else $error("target drives after stop");
   chk_start_quiet: assert property (start_c |=> !dev_sda_oe [*8])
      else $error("target drives after start");
   chk_ack_slot: assert property ($rose(dev_sda_oe) && !rd_frame |-> bit_cnt == 4'h8)
      else $error("target pulls outside ack slot");
   chk_host_ack_slot: assert property (rise_c && rd_frame && !first_byte && bit_cnt == 4'h8
      |-> !dev_sda_oe)
      else $error("target holds line in controller ack slot");
   chk_host_sda_high: assert property ($changed(host_sda_oe) && scl_q && scl_line
      |-> start_c || stop_c)
      else $error("controller data moved with clock high");
endmodule

// >>> verif/sre_tb_top.sv
// Bench joining controller and target ends of the read engine
module sre_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import sre_pkg::*;
   // Arbitrary identifier contents
   localparam logic [127:0] UNIQUE_IDENTIFIER = 128'h0011_2233_4455_6677_8899_aabb_ccdd_eeff;
   logic clk = 1'b0, rst = 1'b1, valid = 1'b0, rdy = 1'b1;
   logic ready, rd_valid, done, nack, lock_c, lock_t, busy;
   sre_cmd_t kind = C_CURRENT;
   logic [7:0] word = 8'h00, cnt = 8'h01, rd_data;
   logic [2:0] cs = 3'h5;
   logic [7:0] got[$];
   int n_fail = 0, check_count = 0, cyc = 0;
   sre_if bus_if();
   sre_target #(.UID_VALUE(UNIQUE_IDENTIFIER)) u_sre_target (.i_core_clk(clk), .i_sys_rst(rst),
      .i_chip_select_pin_high(1'b1), .i_chip_select_pin_mid(1'b0),
      .i_chip_select_pin_low(1'b1), .o_sector_locked(lock_t), .o_busy(busy), .bus(bus_if.dev));
   sre_ctrl #(.SCL_HALF(8), .FIFO_DEPTH(16)) u_sre_ctrl (.i_core_clk(clk), .i_sys_rst(rst),
      .i_cmd_valid(valid), .o_cmd_ready(ready), .i_cmd_kind(kind), .i_cmd_word(word),
      .i_cmd_count(cnt), .i_cmd_cs(cs), .o_rd_data(rd_data), .o_rd_valid(rd_valid),
      .i_rd_ready(rdy), .o_done(done), .o_addr_nack(nack), .o_sector_locked(lock_c),
      .bus(bus_if.host));
   sre_checker u_sre_checker (.i_core_clk(clk), .i_sys_rst(rst),
      .host_scl_o(bus_if.host_scl_o), .host_scl_oe(bus_if.host_scl_oe),
      .host_sda_o(bus_if.host_sda_o), .host_sda_oe(bus_if.host_sda_oe),
      .dev_sda_o(bus_if.dev_sda_o), .dev_sda_oe(bus_if.dev_sda_oe),
      .scl_line(bus_if.scl_line), .sda_line(bus_if.sda_line));
   always #2 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (rd_valid && rdy) begin
         got.push_back(rd_data);
      end
      if (cyc == 40000) begin
         n_fail++;
         tally_and_finish();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // Entered at a falling edge; hold keeps the read side stalled that long
   task automatic run(input sre_cmd_t k, input logic [7:0] w, input logic [7:0] n,
      input logic [2:0] c, input int hold);
      int i;
      got.delete();
      rdy = (hold == 0);
      kind = k;
      word = w;
      cnt = n;
      cs = c;
      valid = 1'b1;
      @(negedge clk);
      valid = 1'b0;
      repeat (hold) @(negedge clk);
      if (hold != 0) begin
         check("stalled busy", ready, 1'b0);
         rdy = 1'b1;
      end
      for (i = 0; i < 20000 && done !== 1'b1; i++) @(negedge clk);
      check("done", done, 1'b1);
      check("target idle", busy, 1'b0);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_select();
      run(C_RANDOM, 8'hff, 8'h01, 3'h2, 0);
      check("miss nack", nack, 1'b1);
      check("miss bytes", 8'(got.size()), 8'h00);
      run(C_RANDOM, 8'hff, 8'h01, 3'h5, 0);
      check("hit nack", nack, 1'b0);
      check("hit bytes", 8'(got.size()), 8'h01);
      check("hit data", got[0], 8'h00);
      run(C_CURRENT, 8'h00, 8'h02, 3'h5, 0);
      check("current bytes", 8'(got.size()), 8'h02);
      check("current data", got[0], 8'h00);
      $display("select test done");
   endtask
   task automatic t_sector();
      run(C_PROBE, 8'h0f, 8'h01, 3'h5, 0);
      check("probe lock", lock_c, 1'b0);
      run(C_PROBE, 8'h00, 8'h01, 3'h5, 0);
      run(C_SECTOR, 8'h0f, 8'h02, 3'h5, 0);
      check("sector bytes", 8'(got.size()), 8'h02);
      check("sector last", got[0], 8'h00);
      check("sector wrap", got[1], 8'h00);
      $display("sector test done");
   endtask
   task automatic t_lock();
      run(C_LOCK, 8'h00, 8'h03, 3'h5, 0);
      check("lock bytes", 8'(got.size()), 8'h03);
      check("lock bit", got[0][1], 1'b0);
      check("lock repeat", got[1], got[0]);
      check("lock repeat", got[2], got[0]);
      check("target lock", lock_t, 1'b0);
      $display("lock test done");
   endtask
   // Eighteen bytes fill the 16-word buffer while stalled, so the bus clock is stretched
   task automatic t_uid_wrap();
      int k;
      run(C_UID, 8'h0e, 8'h12, 3'h5, 5000);
      check("uid bytes", 8'(got.size()), 8'h12);
      for (k = 0; k < 18; k++) begin
         check("uid byte", got[k], UNIQUE_IDENTIFIER[127 - 8 * ((14 + k) % 16) -: 8]);
      end
      $display("uid wrap test done");
   endtask
   initial begin
      repeat (3) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      t_select();
      t_sector();
      t_lock();
      t_uid_wrap();
      tally_and_finish();
   end
endmodule
